// File: logic/sfp_core.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Summary of operation
// - any trip turns off outputs, raises fault
// - trip latched until logic supply cycles
// - sense above short threshold trips protection
// - only sensed current through resistors detected
// - open detection only while PWM chopping
// - positive sense in off-time is event
// - three events confirm open coil
// - fixed confirmation delay before shutdown
// - confirmation delay nominally two microseconds
// - half-microsecond dead time between switches
// - every logic input low-pass filtered
// - sleep input high releases motor drive
// - fault output low normal, high tripped
// - sync high chops both phases together
// - phase input pair selects output drains
module sfp_core
   import sfp_pkg::*;
#(
   parameter int OPP_CYC = OPP_DELAY_CYC,
   parameter int DEAD_CYC = DEAD_TIME_CYC,
   parameter int OFF_CYC = OFF_TIME_CYC
)(
   input wire logic pclk,                          // 250 MHz clock
   input wire logic presetn,                       // logic supply good, low = off
   input wire logic psel,                          // apb select
   input wire logic penable,                       // apb enable
   input wire logic pwrite,                        // apb direction
   input wire logic [7:0] paddr,                   // apb byte address
   input wire logic [31:0] pwdata,                 // apb write data
   output logic [31:0] prdata,                     // apb read data
   output logic pready,                            // apb ready
   output logic pslverr,                           // apb error
   input wire logic [1:0] phase_a_input,           // phase A input pair
   input wire logic [1:0] phase_b_input,           // phase B input pair
   input wire logic blank_sel,                     // high = short blanking
   input wire logic sync_sel,                      // high = synchronized chopping
   input wire logic sleep_req,                     // reference above sleep level
   input wire sfp_pkg::sfp_sense_t sense_a,        // phase A comparators
   input wire sfp_pkg::sfp_sense_t sense_b,        // phase B comparators
   output sfp_pkg::sfp_gate_t gate_a,              // phase A gates
   output sfp_pkg::sfp_gate_t gate_b,              // phase B gates
   output sfp_pkg::sfp_gate_t rect_a,              // phase A rectifier gates
   output sfp_pkg::sfp_gate_t rect_b,              // phase B rectifier gates
   output logic fault_flag,                        // protection tripped
   output logic sleep_active,                      // motor released
   output logic irq                                // interrupt level
);
   import sfp_pkg::*;

   // ==========================================================
   // input filters
   // ==========================================================
   localparam int NIN = 7;
   logic [NIN-1:0] raw_in;
   wire [NIN-1:0] filt_in;
   assign raw_in = {sleep_req, sync_sel, blank_sel, phase_b_input, phase_a_input};

   // majority-free filter: output moves only after FILT_LEN equal samples
   // trade-off: each of the NIN filtered inputs gains a few cycles of latency for glitch immunity
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++)
      begin : g_filt
         logic [FILT_LEN-1:0] sh_reg;
         logic f_reg;
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sh_reg <= '0;
               f_reg <= 1'b0;
            end
            else
            begin
               sh_reg <= {sh_reg[FILT_LEN-2:0], raw_in[gi]};
               if (&sh_reg)
                  f_reg <= 1'b1;
               else if (~|sh_reg)
                  f_reg <= 1'b0;
            end
         end
         assign filt_in[gi] = f_reg;
      end
   endgenerate

   wire [1:0] in_a = filt_in[1:0];
   wire [1:0] in_b = filt_in[3:2];
   wire f_blank = filt_in[4];
   wire f_sync = filt_in[5];
   wire f_sleep = filt_in[6];

   // ==========================================================
   // protection latch
   // ==========================================================
   // only presetn (logic supply cycle) clears the latch; no apb path does
   logic trip_reg;
   logic short_hit;
   logic open_hit;
   logic [1:0] open_conf;
   sfp_sense_t sns [2];
   assign sns[0] = sense_a;
   assign sns[1] = sense_b;
   // comparators sit on the internal resistors, so pin shorts never reach them
   assign short_hit = sense_a.short_trip_threshold | sense_b.short_trip_threshold;
   assign open_hit = |open_conf;

   // no clear path: a trip outlives every input until presetn
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trip_reg <= 1'b0;
      else if (short_hit | open_hit)
         trip_reg <= 1'b1;
   end
   assign fault_flag = trip_reg;

   // ==========================================================
   // pwm chopper per phase
   // ==========================================================
   wire [1:0] in_pair [2];
   assign in_pair[0] = in_a;
   assign in_pair[1] = in_b;
   wire [1:0] trip_in = {sense_b.current_trip, sense_a.current_trip};
   wire [1:0] want_on;
   wire [1:0] in_off_time;
   wire [1:0] at_on;
   wire [1:0] ready_off;
   // synchronized mode: both phases leave off-time together
   // a finished off-time waits here for the other phase
   wire sync_go = f_sync & (&ready_off);
   wire [15:0] blank_cyc = f_blank ? 16'(BLANK_SHORT_CYC) : 16'(BLANK_LONG_CYC);
   sfp_gate_t gate_w [2];
   sfp_gate_t rect_w [2];

   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_ph
         sfp_pwm_t st_reg;
         sfp_pwm_t st_next;
         logic [15:0] cnt_reg;
         logic [15:0] cnt_next;
         logic [1:0] ev_reg;
         logic [15:0] win_reg;
         logic win_act_reg;
         logic conf_reg;
         logic pos_d_reg;
         wire pair_ok = in_pair[gi][0] ^ in_pair[gi][1];
         wire cnt_done = (cnt_reg == 16'h0000);
         wire drive_ok = ~trip_reg & ~f_sleep;
         // rectifier drops DEAD_CYC+1 cycles before on-time so the gate never
         // meets it; OFF_CYC must exceed DEAD_CYC or it never turns on
         wire rect_win = in_off_time[gi] & (cnt_reg > 16'(DEAD_CYC));
         assign want_on[gi] = pair_ok & drive_ok;
         assign in_off_time[gi] = (st_reg == SFP_OFF);
         assign at_on[gi] = (st_reg == SFP_ON);
         assign ready_off[gi] = (st_reg == SFP_OFF) & cnt_done;

         // chopping state sequence with fixed off-time
         // losing drive from any state returns straight to idle
         always_comb
         begin
            st_next = st_reg;
            cnt_next = cnt_done ? 16'h0000 : cnt_reg - 16'h0001;
            case (st_reg)
               SFP_IDLE:
                  if (want_on[gi])
                  begin
                     st_next = SFP_ON;
                     cnt_next = blank_cyc;
                  end
               SFP_ON:
                  if (!want_on[gi])
                     st_next = SFP_IDLE;
                  else if (cnt_done && trip_in[gi])
                  begin
                     st_next = SFP_DEAD;
                     cnt_next = 16'(DEAD_CYC);
                  end
               SFP_DEAD:
                  if (!want_on[gi])
                     st_next = SFP_IDLE;
                  else if (cnt_done)
                  begin
                     st_next = SFP_OFF;
                     cnt_next = 16'(OFF_CYC);
                  end
               SFP_OFF:
                  if (!want_on[gi])
                     st_next = SFP_IDLE;
                  else if (cnt_done && (!f_sync || sync_go))
                  begin
                     st_next = SFP_ON;
                     cnt_next = blank_cyc;
                  end
               default:
                  st_next = SFP_IDLE;
            endcase
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               st_reg <= SFP_IDLE;
               cnt_reg <= 16'h0000;
            end
            else
            begin
               st_reg <= st_next;
               cnt_reg <= cnt_next;
            end
         end

         // open-coil events: rising positive sense during off-time
         // window runs OPP_CYC+1 cycles from the first event; count saturates
         wire ev = in_off_time[gi] & sns[gi].sense_positive & ~pos_d_reg;
         wire win_end = win_act_reg & (win_reg == 16'h0000);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pos_d_reg <= 1'b0;
               ev_reg <= 2'h0;
               win_reg <= 16'h0000;
               win_act_reg <= 1'b0;
               conf_reg <= 1'b0;
            end
            else
            begin
               pos_d_reg <= sns[gi].sense_positive & in_off_time[gi];
               if (ev && !win_act_reg)
               begin
                  win_act_reg <= 1'b1;
                  win_reg <= 16'(OPP_CYC);
                  ev_reg <= 2'h1;
               end
               else if (win_end)
               begin
                  win_act_reg <= 1'b0;
                  // count reached within delay: confirm; else clear
                  conf_reg <= (ev_reg == 2'(OPEN_EVENTS));
                  ev_reg <= 2'h0;
               end
               else if (win_act_reg)
               begin
                  win_reg <= win_reg - 16'h0001;
                  if (ev && ev_reg != 2'(OPEN_EVENTS))
                     ev_reg <= ev_reg + 2'h1;
               end
            end
         end
         assign open_conf[gi] = conf_reg;

         // main and rectifier gates; dead state has both off
         // pair_ok again: an equal pair must not light both for one cycle
         assign gate_w[gi] = {at_on[gi] & pair_ok & in_pair[gi][0],
            at_on[gi] & pair_ok & in_pair[gi][1]};
         assign rect_w[gi] = {rect_win & pair_ok & in_pair[gi][1],
            rect_win & pair_ok & in_pair[gi][0]};
      end
   endgenerate

   // registered gate outputs; the raw short and filtered sleep also cut them so a
   // short is off at the first edge, the same edge that sets the latch
   wire drive_kill = trip_reg | short_hit | f_sleep;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_a <= '0;
         gate_b <= '0;
         rect_a <= '0;
         rect_b <= '0;
      end
      else
      begin
         gate_a <= drive_kill ? '0 : gate_w[0];
         gate_b <= drive_kill ? '0 : gate_w[1];
         rect_a <= drive_kill ? '0 : rect_w[0];
         rect_b <= drive_kill ? '0 : rect_w[1];
      end
   end
   assign sleep_active = f_sleep;

   // ==========================================================
   // apb registers and interrupt
   // ==========================================================
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_en_reg;
   logic [1:0] ctrl_reg;
   logic sleep_d_reg;
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_stat = (paddr == ADDR_STAT);
   wire hit_is = (paddr == ADDR_IRQ_STAT);
   wire hit_ie = (paddr == ADDR_IRQ_EN);
   wire hit_ic = (paddr == ADDR_IRQ_CLR);
   wire mapped = hit_ctrl | hit_stat | hit_is | hit_ie | hit_ic;
   wire [2:0] ev_set = {f_sleep & ~sleep_d_reg, open_hit & ~trip_reg, short_hit & ~trip_reg};
   wire [2:0] clr = (wr && hit_ic) ? pwdata[2:0] : 3'h0;
   // status word packs live state for polling without the interrupt
   wire [31:0] stat_word = {24'h0, ctrl_reg, sleep_active, f_sync, open_conf, short_hit, trip_reg};

   // ctrl bits are scratch masks for software; they never clear the trip
   // irq clear is write-only and reads back as zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= 3'h0;
         irq_en_reg <= IRQ_EN_RST;
         ctrl_reg <= CTRL_RST;
         sleep_d_reg <= 1'b0;
      end
      else
      begin
         sleep_d_reg <= f_sleep;
         irq_stat_reg <= (irq_stat_reg & ~clr) | ev_set; // set wins
         if (wr && hit_ie)
            irq_en_reg <= pwdata[2:0];
         if (wr && hit_ctrl)
            ctrl_reg <= pwdata[1:0];
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);
   // no wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   // unmapped offsets answer with pslverr and read as zero
   assign pslverr = acc & ~mapped;
   assign prdata = !acc ? 32'h0 :
                   hit_ctrl ? {30'h0, ctrl_reg} :
                   hit_stat ? stat_word :
                   hit_is ? {29'h0, irq_stat_reg} :
                   hit_ie ? {29'h0, irq_en_reg} : 32'h0;
endmodule

// File: logic/sfp_pkg.sv
package sfp_pkg;
   // ==========================================================
   // timing
   // ==========================================================
   localparam int CLK_MHZ = 250;
   localparam int OPP_DELAY_NS = 2000;
   localparam int OPP_DELAY_CYC = (OPP_DELAY_NS * CLK_MHZ) / 1000;
   localparam int DEAD_TIME_NS = 500;
   localparam int DEAD_TIME_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT_LEN = 4;
   localparam int OPEN_EVENTS = 3;
   localparam int OFF_TIME_CYC = 1000;
   localparam int BLANK_LONG_CYC = 1300;
   localparam int BLANK_SHORT_CYC = 800;

   // ==========================================================
   // apb register map
   // ==========================================================
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [2:0] IRQ_EN_RST = 3'h0;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int IRQ_SHORT_BIT = 0;
   localparam int IRQ_OPEN_BIT = 1;
   localparam int IRQ_SLEEP_BIT = 2;

   // per-phase analog comparator results
   typedef struct packed {
      logic short_trip_threshold; // sense_voltage above short trip level
      logic sense_positive;       // sense_voltage positive
      logic current_trip;         // sense_voltage above regulation level
   } sfp_sense_t;

   // per-phase gate drive pair
   typedef struct packed {
      logic phase_a_output;
      logic phase_b_output;
   } sfp_gate_t;

   typedef enum logic [3:0] {
      SFP_ON   = 4'b0001,
      SFP_DEAD = 4'b0010,
      SFP_OFF  = 4'b0100,
      SFP_IDLE = 4'b1000
   } sfp_pwm_t;
endpackage

// File: verif/sfp_core_monitor.sv
`timescale 1ns/1ns
module sfp_core_monitor
   import sfp_pkg::*;
#(
   parameter int OPP_CYC = OPP_DELAY_CYC
)(
   input wire logic pclk, // clock
   input wire logic presetn, // async reset
   input wire logic [1:0] phase_a_input, // phase A pair
   input wire sfp_pkg::sfp_sense_t sense_a, // phase A sense
   input wire sfp_pkg::sfp_sense_t sense_b, // phase B sense
   input wire sfp_pkg::sfp_gate_t gate_a, // phase A gates
   input wire sfp_pkg::sfp_gate_t gate_b, // phase B gates
   input wire sfp_pkg::sfp_gate_t rect_a, // phase A rectifier
   input wire sfp_pkg::sfp_gate_t rect_b, // phase B rectifier
   input wire logic fault_flag, // tripped
   input wire logic sleep_active // motor released
);
   // ======
   // helpers
   // slack covers the confirm pipeline and trip latch; sense inputs are not filtered
   localparam int LIM = OPP_CYC + 16;
   int quiet_cnt;
   logic any_sense;
   logic all_off;
   assign any_sense = sense_a.sense_positive | sense_b.sense_positive
      | sense_a.short_trip_threshold | sense_b.short_trip_threshold;
   assign all_off = ({gate_a, gate_b, rect_a, rect_b} == 8'h00);
   // cycles since any sense activity, saturating so it never wraps
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         quiet_cnt <= 0;
      else if (any_sense)
         quiet_cnt <= 0;
      else if (quiet_cnt < LIM)
         quiet_cnt <= quiet_cnt + 1;
   end
   // ======
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_pair_a_on;
      (phase_a_input == 2'h1)[*8];
   endsequence
   sequence s_pair_equal;
      (phase_a_input[1] == phase_a_input[0])[*8];
   endsequence
   a_fault_kills_drive: assert property (fault_flag |=> all_off)
      else $error("drive active while tripped");
   a_fault_sticks: assert property (fault_flag |=> fault_flag)
      else $error("fault cleared without reset");
   a_short_trips: assert property (sense_a.short_trip_threshold[*6] |-> ##[0:4] fault_flag)
      else $error("short did not trip");
   a_trip_has_cause: assert property ($rose(fault_flag) |-> quiet_cnt < LIM)
      else $error("trip without sense activity");
   a_rect_excl: assert property ((gate_a != 2'h0) |-> (rect_a == 2'h0))
      else $error("gate and rectifier both on");
   a_dead_gap: assert property ($fell(gate_a.phase_a_output) |-> (rect_a == 2'h0)[*8])
      else $error("rectifier on inside dead time");
   a_dead_back: assert property ($fell(rect_a.phase_b_output) |-> (gate_a == 2'h0)[*8])
      else $error("gate on inside dead time");
   a_b_short: assert property (sense_b.short_trip_threshold[*2] |-> ##[0:2] fault_flag)
      else $error("phase B short did not trip");
   a_sleep_release: assert property (sleep_active |=> all_off)
      else $error("drive active in sleep");
   a_equal_off: assert property (s_pair_equal |-> gate_a == 2'h0)
      else $error("equal pair left a gate on");
   a_pair_select: assert property (s_pair_a_on |-> !gate_a.phase_b_output)
      else $error("wrong output of pair on");
endmodule
bind sfp_core sfp_core_monitor #(.OPP_CYC(OPP_CYC)) i_mon (.pclk(pclk), .presetn(presetn),
   .phase_a_input(phase_a_input), .sense_a(sense_a), .sense_b(sense_b), .gate_a(gate_a),
   .gate_b(gate_b), .rect_a(rect_a), .rect_b(rect_b), .fault_flag(fault_flag),
   .sleep_active(sleep_active));

// File: verif/sfp_mcu_model.sv
`timescale 1ns/1ns
module sfp_mcu_model
#(
   parameter int WAKE_CYC = 25000
)(
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic [1:0] want_a, // requested phase A pair
   input wire logic [1:0] want_b, // requested phase B pair
   input wire logic want_sleep, // requested sleep
   output logic [1:0] phase_a_input, // to block
   output logic [1:0] phase_b_input, // to block
   output logic blank_sel, // to block
   output logic sync_sel, // to block
   output logic sleep_req // to block
);
   int wake_cnt;
   // every pin held at a definite level, even in reset; phases held after wake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {phase_a_input, phase_b_input, blank_sel, sync_sel, sleep_req} <= 7'h00;
         wake_cnt <= 0;
      end
      else
      begin
         sleep_req <= want_sleep;
         blank_sel <= 1'b1;
         sync_sel <= 1'b0;
         if (sleep_req && !want_sleep)
            wake_cnt <= WAKE_CYC;
         else if (wake_cnt != 0)
            wake_cnt <= wake_cnt - 1;
         if (wake_cnt == 0)
         begin
            phase_a_input <= want_a;
            phase_b_input <= want_b;
         end
      end
   end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import sfp_pkg::*;
   localparam int OPP = 40;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, errq;
   logic fault_flag, sleep_active, blank_sel, sync_sel, sleep_req, want_sleep;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdq;
   logic [1:0] want_a, want_b, phase_a_input, phase_b_input;
   sfp_sense_t sense_a, sense_b;
   sfp_gate_t gate_a, gate_b, rect_a, rect_b;
   int n_fail, num_checks;
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   sfp_core #(.OPP_CYC(OPP), .DEAD_CYC(125), .OFF_CYC(200)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phase_a_input(phase_a_input), .phase_b_input(phase_b_input), .blank_sel(blank_sel),
      .sync_sel(sync_sel), .sleep_req(sleep_req), .sense_a(sense_a), .sense_b(sense_b),
      .gate_a(gate_a), .gate_b(gate_b), .rect_a(rect_a), .rect_b(rect_b),
      .fault_flag(fault_flag), .sleep_active(sleep_active), .irq(irq));
   sfp_mcu_model #(.WAKE_CYC(50)) i_mcu (.pclk(pclk), .presetn(presetn), .want_a(want_a),
      .want_b(want_b), .want_sleep(want_sleep), .phase_a_input(phase_a_input),
      .phase_b_input(phase_b_input), .blank_sel(blank_sel), .sync_sel(sync_sel),
      .sleep_req(sleep_req));
   // ======
   // shared tasks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s exp %0h got %0h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rdq = prdata;
      errq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
      begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   // wait for an off-time, then give ev positive sense pulses
   task automatic chop(input int ev);
      int k;
      for (k = 0; k < 3000 && rect_a === 2'h0; k++) @(posedge pclk);
      if (k == 3000)
      begin
         n_fail++;
         tally_and_finish();
      end
      else
      begin
         repeat (ev)
         begin
            sense_a.sense_positive <= 1'b1;
            tick(6);
            sense_a.sense_positive <= 1'b0;
            tick(6);
         end
         tick(OPP + 20);
      end
   endtask
   // ======
   // scenarios
   task automatic t_sleep;
      want_a <= 2'h1;
      tick(20);
      chk("gate_a", 32'h2, {30'h0, gate_a});
      want_sleep <= 1'b1;
      tick(20);
      chk("sleep_active", 32'h1, {31'h0, sleep_active});
      chk("gates", 32'h0, {28'h0, gate_a, rect_a});
      want_sleep <= 1'b0;
      tick(10);
      chk("sleep_active", 32'h0, {31'h0, sleep_active});
   endtask
   task automatic t_table;
      logic [1:0] exp [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
      for (int i = 0; i < 4; i++)
      begin
         want_a <= 2'(i);
         want_b <= 2'(i);
         tick(200);
         chk("gate_a", {30'h0, exp[i]}, {30'h0, gate_a});
         chk("gate_b", {30'h0, exp[i]}, {30'h0, gate_b});
      end
   endtask
   task automatic t_open;
      sense_a.current_trip <= 1'b1;
      want_a <= 2'h1;
      want_b <= 2'h1;
      chop(2);
      chk("fault_flag", 32'h0, {31'h0, fault_flag});
      chop(1);
      chk("fault_flag", 32'h0, {31'h0, fault_flag});
      chop(3);
      chk("fault_flag", 32'h1, {31'h0, fault_flag});
      chk("drive", 32'h0, {24'h0, gate_a, rect_a, gate_b, rect_b});
      want_a <= 2'h2;
      sense_a.current_trip <= 1'b0;
      tick(50);
      chk("fault_flag", 32'h1, {31'h0, fault_flag});
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h1 << IRQ_OPEN_BIT, rdq & (32'h1 << IRQ_OPEN_BIT));
   endtask
   task automatic t_short;
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      want_a <= 2'h1;
      tick(20);
      chk("fault_flag", 32'h0, {31'h0, fault_flag});
      sense_a.short_trip_threshold <= 1'b1;
      tick(10);
      sense_a.short_trip_threshold <= 1'b0;
      tick(10);
      chk("fault_flag", 32'h1, {31'h0, fault_flag});
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_EN, 32'h1 << IRQ_SHORT_BIT);
      tick(2);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_CLR, 32'h1 << IRQ_SHORT_BIT);
      tick(2);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b0, 8'h14, 32'h0);
      chk("pslverr", 32'h1, {31'h0, errq});
      chk("prdata", 32'h0, rdq);
   endtask
   task automatic t_short_b;
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      want_b <= 2'h1;
      tick(20);
      chk("gate_b", 32'h2, {30'h0, gate_b});
      sense_b.short_trip_threshold <= 1'b1;
      tick(3);
      sense_b.short_trip_threshold <= 1'b0;
      tick(3);
      chk("fault_flag", 32'h1, {31'h0, fault_flag});
      chk("gate_b", 32'h0, {30'h0, gate_b});
   endtask
   // ======
   // main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, want_sleep, errq} = 6'h00;
      {paddr, pwdata, rdq} = 72'h0;
      {want_a, want_b} = 4'h0;
      sense_a = 3'h0;
      sense_b = 3'h0;
      tick(2);
      presetn <= 1'b1;
      tick(1);
      t_sleep();
      t_table();
      t_open();
      t_short();
      t_short_b();
      tally_and_finish();
   end
endmodule
